/* File: rtl/dcrb_register_bank.sv */
module dcrb_register_bank (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // Serial port, inputs synchronous to core_clk
  input  wire logic               spiCsN,
  input  wire logic               spiSclk,
  input  wire logic               spiDataIn,
  output logic                    spiDataOut,
  output logic                    spiDataOe,
  // Status from the rest of the device
  input  wire logic               pllLock,
  input  wire dcrb_pkg::dcrb_evt_s evtIn,
  input  wire logic               fifoResetDone,
  // Controls to the rest of the device
  output logic                    deviceReset,
  output dcrb_pkg::dcrb_ctrl_s    ctrl,
  output dcrb_pkg::dcrb_evt_s     irqEnable,
  output logic                    fifoSyncFlag,
  output logic                    pllLostFlag,
  output logic                    irqPending
);

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      reverse8[i] = v[7 - i];
    end
  endfunction : reverse8

  logic [7:0] serialCfg;
  logic [7:0] powerCtrl;
  logic [7:0] dataFmt;
  logic [7:0] irqEn1;
  logic       sclkPrev;
  logic [4:0] bitCount;
  logic [15:0] shiftIn;
  logic [6:0] frameAddr;
  logic [7:0] shiftOut;
  logic       readCycle;
  logic       pllPrev;

  // Serial clock edge detection
  wire        sclkRise  = spiSclk & ~sclkPrev & ~spiCsN;
  wire        sclkFall  = ~spiSclk & sclkPrev & ~spiCsN;
  wire        lsbFirst  = serialCfg[dcrb_pkg::BIT_LSB_FIRST];
  // Header complete after 8 bits; address follows the direction bit MSB first, precedes it LSB first
  wire [7:0]  hdrRaw    = {shiftIn[6:0], spiDataIn};
  wire [7:0]  hdr       = lsbFirst ? reverse8(hdrRaw) : hdrRaw; // RULE2
  wire        hdrDone   = sclkRise && (bitCount == 5'd7);
  wire        dataDone  = sclkRise && (bitCount == 5'(dcrb_pkg::FRAME_BITS - 1));
  wire [7:0]  wrRaw     = {shiftIn[6:0], spiDataIn};
  wire [7:0]  wrData    = lsbFirst ? reverse8(wrRaw) : wrRaw; // RULE2
  // Address kept from the decoded header, so bit order needs no second pass
  wire [6:0]  wrAddr    = frameAddr;
  wire        doWrite   = dataDone && !readCycle;
  wire [6:0]  rdAddr    = hdr[6:0];

  wire [7:0]  lockByte  = 8'(pllLock) << dcrb_pkg::BIT_LOCK;
  wire [7:0]  rdMux =
    (rdAddr == dcrb_pkg::ADDR_SERIAL_CFG) ? serialCfg :
    (rdAddr == dcrb_pkg::ADDR_POWER_CTRL) ? (powerCtrl | lockByte) :
    (rdAddr == dcrb_pkg::ADDR_DATA_FMT)   ? dataFmt :
    (rdAddr == dcrb_pkg::ADDR_IRQ_EN1)    ? irqEn1 : 8'h00; // RULE16
  wire [7:0]  rdWord    = lsbFirst ? reverse8(rdMux) : rdMux; // RULE2

  wire        pllLostEvt = pllPrev & ~pllLock; // RULE15
  wire [5:0]  evtVec     = {evtIn.pllLost | pllLostEvt, evtIn.pllLocked, evtIn.syncLost,
                            evtIn.syncLocked, evtIn.clkReady, evtIn.fifoSync | fifoResetDone};
  wire [5:0]  enVec      = irqEn1[7:2]; // RULE10 RULE11 RULE12 RULE13
  wire        next_irq   = |(evtVec & enVec) | irqPending;

  // Frame bit counter and shifter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclkPrev  <= 1'b0;
      bitCount  <= 5'h00;
      shiftIn   <= 16'h0000;
      frameAddr <= 7'h00;
      readCycle <= 1'b0;
    end else begin
      sclkPrev <= spiSclk;
      if (spiCsN) begin
        bitCount  <= 5'h00;
        readCycle <= 1'b0;
      end else if (sclkRise) begin
        shiftIn  <= {shiftIn[14:0], spiDataIn};
        bitCount <= (bitCount == 5'(dcrb_pkg::FRAME_BITS - 1)) ? 5'h00 : bitCount + 5'h01;
        if (hdrDone) begin
          readCycle <= hdr[7];
          frameAddr <= hdr[6:0]; // RULE2
        end
      end
    end
  end

  // Register writes; soft reset bit survives its own effect
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serialCfg <= dcrb_pkg::RST_VALUE;
      powerCtrl <= dcrb_pkg::RST_VALUE;
      dataFmt   <= dcrb_pkg::RST_VALUE;
      irqEn1    <= dcrb_pkg::RST_VALUE;
    end else if (doWrite) begin
      case (wrAddr)
        dcrb_pkg::ADDR_SERIAL_CFG: serialCfg <= wrData & dcrb_pkg::MASK_SERIAL_CFG; // RULE1 RULE3
        dcrb_pkg::ADDR_POWER_CTRL: powerCtrl <= wrData & dcrb_pkg::MASK_POWER_CTRL; // RULE4 RULE5
        dcrb_pkg::ADDR_DATA_FMT: begin
          // Write with an invalid width code dropped whole; the old format stays in force
          if (wrData[1:0] != 2'h3) begin // RULE9
            dataFmt <= wrData & dcrb_pkg::MASK_DATA_FMT;
          end
        end
        dcrb_pkg::ADDR_IRQ_EN1:    irqEn1 <= wrData & dcrb_pkg::MASK_IRQ_EN1;
        default: ;
      endcase
    end
  end

  // Read data path
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shiftOut   <= 8'h00;
      spiDataOut <= 1'b0;
      spiDataOe  <= 1'b0;
    end else begin
      if (hdrDone) begin
        shiftOut <= rdWord;
      end else if (sclkFall && readCycle) begin
        spiDataOut <= shiftOut[7];
        shiftOut   <= {shiftOut[6:0], 1'b0};
      end
      // Drive only in the data phase of a read, and only if enabled
      spiDataOe <= !spiCsN && readCycle && serialCfg[dcrb_pkg::BIT_PIN_DIR]; // RULE1
    end
  end

  // Latched flags: set wins over the soft reset clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pllPrev      <= 1'b0;
      fifoSyncFlag <= 1'b0;
      pllLostFlag  <= 1'b0;
      irqPending   <= 1'b0;
    end else begin
      pllPrev <= pllLock;
      if (fifoResetDone) begin
        fifoSyncFlag <= 1'b1; // RULE14
      end else if (deviceReset) begin
        fifoSyncFlag <= 1'b0;
      end
      if (pllLostEvt) begin
        pllLostFlag <= 1'b1; // RULE15
      end else if (deviceReset) begin
        pllLostFlag <= 1'b0;
      end
      irqPending <= deviceReset ? |(evtVec & enVec) : next_irq;
    end
  end

  // Control outputs registered
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      deviceReset <= 1'b0;
      ctrl        <= '0;
      irqEnable   <= '0;
    end else begin
      deviceReset        <= serialCfg[dcrb_pkg::BIT_SOFT_RST]; // RULE3
      ctrl.pdI           <= powerCtrl[dcrb_pkg::BIT_PD_I]; // RULE4
      ctrl.pdQ           <= powerCtrl[dcrb_pkg::BIT_PD_Q]; // RULE4
      ctrl.pdRx          <= powerCtrl[dcrb_pkg::BIT_PD_RX]; // RULE4
      ctrl.pdAux         <= powerCtrl[dcrb_pkg::BIT_PD_AUX]; // RULE5
      ctrl.offsetBinary  <= dataFmt[dcrb_pkg::BIT_OFFS_BIN]; // RULE6
      ctrl.qFirst        <= dataFmt[dcrb_pkg::BIT_Q_FIRST]; // RULE7
      ctrl.bitSwap       <= dataFmt[dcrb_pkg::BIT_SWAP]; // RULE8
      ctrl.busWidth      <= dataFmt[1:0]; // RULE9
      irqEnable          <= dcrb_pkg::dcrb_evt_s'(enVec);
    end
  end

endmodule : dcrb_register_bank

/* File: rtl/dcrb_pkg.sv */
// Functional notes
// [RULE1] Config bit 7 set lets the data pin drive read data back out.
// [RULE2] Config bit 6 picks serial bit order: 0 MSB first, 1 LSB first.
// [RULE3] Config bit 5 written 1 holds the device in reset until written 0.
// [RULE4] Power bits 7, 6, 5 power down I converter, Q converter, data receiver.
// [RULE5] Power bit 4 powers down the temperature sensing auxiliary converter.
// [RULE6] Format bit 7: 0 two's complement samples, 1 offset binary samples.
// [RULE7] Format bit 6: 0 I sample first, 1 Q sample first in each pair.
// [RULE8] Format bit 5 set reverses the input data port bit order.
// [RULE9] Format field [1:0]: 00 dual word, 01 word, 10 byte; 11 invalid.
// [RULE10] Enable bit 7 gates lock-lost, bit 6 gates lock-acquired interrupts.
// [RULE11] Enable bit 5 gates sync-lost, bit 4 gates sync-locked interrupts.
// [RULE12] Enable bit 3 gates the clock generation ready interrupt.
// [RULE13] Enable bit 2 gates the soft FIFO reset done interrupt.
// [RULE14] A latched flag is set when a serial requested FIFO reset finishes.
// [RULE15] A latched flag is set when a previously locked PLL unlocks.
// [RULE16] Undefined bits read zero, ignore writes; defined bits reset cleared.
package dcrb_pkg;

  localparam logic [6:0] ADDR_SERIAL_CFG = 7'h00;
  localparam logic [6:0] ADDR_POWER_CTRL = 7'h01;
  localparam logic [6:0] ADDR_DATA_FMT   = 7'h03;
  localparam logic [6:0] ADDR_IRQ_EN1    = 7'h04;

  localparam logic [7:0] RST_VALUE = 8'h00;

  localparam logic [7:0] MASK_SERIAL_CFG = 8'he0;
  localparam logic [7:0] MASK_POWER_CTRL = 8'hf0;
  localparam logic [7:0] MASK_DATA_FMT   = 8'he3;
  localparam logic [7:0] MASK_IRQ_EN1    = 8'hfc;

  localparam int BIT_PIN_DIR   = 7;
  localparam int BIT_LSB_FIRST = 6;
  localparam int BIT_SOFT_RST  = 5;
  localparam int BIT_PD_I      = 7;
  localparam int BIT_PD_Q      = 6;
  localparam int BIT_PD_RX     = 5;
  localparam int BIT_PD_AUX    = 4;
  localparam int BIT_LOCK      = 0;
  localparam int BIT_OFFS_BIN  = 7;
  localparam int BIT_Q_FIRST   = 6;
  localparam int BIT_SWAP      = 5;

  localparam logic [1:0] BUS_DUAL_WORD = 2'h0;
  localparam logic [1:0] BUS_WORD      = 2'h1;
  localparam logic [1:0] BUS_BYTE      = 2'h2;

  // Serial frame: 1 direction bit, 7 address bits, 8 data bits
  localparam int FRAME_BITS = 16;

  typedef struct packed {
    logic       pdI;
    logic       pdQ;
    logic       pdRx;
    logic       pdAux;
    logic       offsetBinary;
    logic       qFirst;
    logic       bitSwap;
    logic [1:0] busWidth;
  } dcrb_ctrl_s;

  typedef struct packed {
    logic pllLost;
    logic pllLocked;
    logic syncLost;
    logic syncLocked;
    logic clkReady;
    logic fifoSync;
  } dcrb_evt_s;

endpackage : dcrb_pkg

/* File: dv/dcrb_register_bank_monitor.sv */
module dcrb_register_bank_monitor (
  // Clock, reset and serial port
  input wire logic                 core_clk,
  input wire logic                 rstn,
  input wire logic                 spiCsN,
  input wire logic                 spiSclk,
  input wire logic                 spiDataIn,
  input wire logic                 spiDataOut,
  input wire logic                 spiDataOe,
  // Device side
  input wire logic                 pllLock,
  input wire dcrb_pkg::dcrb_evt_s  evtIn,
  input wire logic                 fifoResetDone,
  input wire logic                 deviceReset,
  input wire dcrb_pkg::dcrb_ctrl_s ctrl,
  input wire dcrb_pkg::dcrb_evt_s  irqEnable,
  input wire logic                 fifoSyncFlag,
  input wire logic                 pllLostFlag,
  input wire logic                 irqPending
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_reset_clears: assert property ($rose(rstn) |-> !deviceReset && ctrl == '0 && irqEnable == '0)
    else $error("outputs not clear after reset");
  a_oe_in_frame: assert property (spiDataOe |-> !$past(spiCsN))
    else $error("data pin driven outside a frame");
  a_oe_quiet_start: assert property ($fell(spiCsN) |-> !spiDataOe)
    else $error("data pin driven at frame start");
  a_ctrl_holds_idle: assert property (spiCsN && $past(spiCsN, 3) |-> $stable(ctrl) && $stable(irqEnable))
    else $error("controls changed with no frame");
  a_width_legal: assert property (ctrl.busWidth != 2'h3)
    else $error("invalid bus width code taken");
  a_fifo_flag_set: assert property (fifoResetDone |=> fifoSyncFlag)
    else $error("fifo sync flag not set");
  a_fifo_flag_sticky: assert property (fifoSyncFlag && !deviceReset ##1 !deviceReset |-> fifoSyncFlag)
    else $error("fifo sync flag dropped");
  a_lost_flag_sticky: assert property (pllLostFlag && !deviceReset ##1 !deviceReset |-> pllLostFlag)
    else $error("lock lost flag dropped");
  a_soft_reset_clears: assert property (deviceReset && !fifoResetDone |=> !fifoSyncFlag)
    else $error("soft reset left flag set");

  cover property (spiDataOe);
  cover property ($rose(deviceReset));
  cover property ($rose(fifoSyncFlag));
endmodule : dcrb_register_bank_monitor

bind dcrb_register_bank dcrb_register_bank_monitor u_mon (.core_clk(core_clk), .rstn(rstn),
  .spiCsN(spiCsN), .spiSclk(spiSclk), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
  .spiDataOe(spiDataOe), .pllLock(pllLock), .evtIn(evtIn), .fifoResetDone(fifoResetDone),
  .deviceReset(deviceReset), .ctrl(ctrl), .irqEnable(irqEnable), .fifoSyncFlag(fifoSyncFlag),
  .pllLostFlag(pllLostFlag), .irqPending(irqPending));

/* File: dv/dcrb_host_model.sv */
module dcrb_host_model (
  // Clock
  input wire logic core_clk,
  // Host lines
  output logic     spiCsN,
  output logic     spiSclk,
  output logic     hostDrv,
  // Resolved data pin
  input wire logic sdio
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    hostDrv = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input logic lsb, output logic [7:0] q);
    logic [15:0] f;
    int          k;
    f = {rd, a, d};
    q = 8'h00;
    tick(1);
    spiCsN = 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = lsb ? (i < 8 ? i + 8 : i - 8) : 15 - i;
      spiSclk = 1'b0;
      // Released pin flips so a stale level never passes as data
      hostDrv = (rd && i > 7) ? ~hostDrv : f[k];
      tick(4);
      if (rd && i > 7) q[k] = sdio;
      spiSclk = 1'b1;
      tick(4);
    end
    spiCsN = 1'b1;
    hostDrv = ~hostDrv;
    tick(1);
    spiSclk = 1'b0;
    tick(2);
  endtask : xfer
endmodule : dcrb_host_model

/* File: dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", n, e, s); end end

  logic                 core_clk, rstn, spiCsN, spiSclk, hostDrv, pllLock, fifoResetDone;
  logic                 spiDataOut, spiDataOe, deviceReset, fifoSyncFlag, pllLostFlag, irqPending;
  dcrb_pkg::dcrb_evt_s  evtIn, irqEnable;
  dcrb_pkg::dcrb_ctrl_s ctrl;
  logic [7:0]           mdl [128];
  logic [7:0]           q;
  logic                 lsb;
  int                   failures, tests_run, cycles;
  wire logic            sdio = spiDataOe ? spiDataOut : hostDrv;

  dcrb_register_bank dut (.core_clk(core_clk), .rstn(rstn), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiDataIn(sdio), .spiDataOut(spiDataOut), .spiDataOe(spiDataOe), .pllLock(pllLock),
    .evtIn(evtIn), .fifoResetDone(fifoResetDone), .deviceReset(deviceReset), .ctrl(ctrl),
    .irqEnable(irqEnable), .fifoSyncFlag(fifoSyncFlag), .pllLostFlag(pllLostFlag),
    .irqPending(irqPending));
  dcrb_host_model host (.core_clk(core_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .hostDrv(hostDrv), .sdio(sdio));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  function automatic logic [7:0] msk(input logic [6:0] a);
    case (a)
      dcrb_pkg::ADDR_SERIAL_CFG: return dcrb_pkg::MASK_SERIAL_CFG;
      dcrb_pkg::ADDR_POWER_CTRL: return dcrb_pkg::MASK_POWER_CTRL;
      dcrb_pkg::ADDR_DATA_FMT:   return dcrb_pkg::MASK_DATA_FMT;
      dcrb_pkg::ADDR_IRQ_EN1:    return dcrb_pkg::MASK_IRQ_EN1;
      default:                   return 8'h00;
    endcase
  endfunction : msk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, lsb, q);
    if (a == 7'h00) lsb = d[6];
    if (a != 7'h03 || d[1:0] != 2'h3) mdl[a] = d & msk(a);
    `CHK("ctrl", {mdl[1][7:4], mdl[3][7:5], mdl[3][1:0]}, ctrl)
    `CHK("irqEnable", mdl[4][7:2], irqEnable)
    `CHK("deviceReset", mdl[0][5], deviceReset)
  endtask : wr

  task automatic rd(input logic [6:0] a);
    host.xfer(1'b1, a, 8'h00, lsb, q);
    `CHK("readback", mdl[a] | {7'h00, a == 7'h01 && pllLock}, q)
  endtask : rd

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  initial begin
    logic [6:0] a;
    logic [7:0] d;
    rstn = 1'b0;
    pllLock = 1'b0;
    evtIn = '0;
    fifoResetDone = 1'b0;
    lsb = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    void'($urandom(32'hb0c2));
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'b1;
    `CHK("resetCtrl", 9'h000, ctrl)
    wr(7'h00, 8'h80);
    for (int i = 0; i < 6; i++) rd(i[6:0]);
    $display("reset values done");
    wr(7'h03, 8'hff);
    wr(7'h00, 8'hc0);
    rd(7'h03);
    for (int n = 0; n < 16; n++) begin
      a = 7'($urandom_range(5));
      d = 8'($urandom);
      // Pin stays two-way and soft reset stays off so reads keep working
      if (a == 7'h00) d = {1'b1, d[6], 1'b0, d[4:0]};
      pllLock = d[0];
      evtIn = 6'($urandom);
      wr(a, d);
      rd(a);
    end
    $display("random access done");
    evtIn = '0;
    wr(7'h04, 8'h04);
    @(posedge core_clk);
    #1 fifoResetDone = 1'b1;
    @(posedge core_clk);
    #1 fifoResetDone = 1'b0;
    `CHK("fifoSyncFlag", 1'b1, fifoSyncFlag)
    `CHK("irqPending", 1'b1, irqPending)
    wr(7'h00, {2'b10, 6'h20});
    `CHK("flagCleared", 1'b0, fifoSyncFlag)
    wr(7'h00, 8'h80);
    `CHK("pendCleared", 1'b0, irqPending)
    `CHK("lostClear", 1'b0, pllLostFlag)
    pllLock = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 pllLock = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("pllLostFlag", 1'b1, pllLostFlag)
    rd(7'h04);
    $display("soft reset done");
    test_done();
  end
endmodule : tb_top
